// ===== logic/slm_pkg.sv
/*
  Constants, register map and carrier types of the sleep-mode controller.
  Assumes an 8-bit register port and a single 50 MHz system clock.
*/
`default_nettype none
package slm_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_CTRL_STAT = 3'h1;
  localparam logic [2:0] OFS_CTRL_EXT = 3'h2;
  localparam logic [2:0] OFS_AUX = 3'h3;
  localparam logic [2:0] OFS_STATE = 3'h4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int ARM_BIT = 5;
  localparam int SEL_MID_BIT = 4;
  localparam int SEL_HI_BIT = 5;
  localparam int SEL_LO_BIT = 7;
  localparam int SENSE0_LSB = 0;
  localparam int SENSE1_LSB = 2;
  localparam logic [1:0] SENSE_LEVEL = 2'h0;
  localparam int T2_ASYNC_BIT = 0;
  localparam int CMP_OFF_BIT = 1;
  localparam logic [3:0] XTAL_MIN_CODE = 4'h8;
  localparam int CNT_W = 15;
  localparam int HALT_CK = 4;
  localparam int STBY_CK = 6;
  localparam int START_CK0 = 6;
  localparam int START_CK1 = 258;
  localparam int START_CK2 = 1024;
  localparam int START_CK3 = 16384;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_PDOWN = 3'h2,
    MODE_PSAVE = 3'h3,
    MODE_STBY = 3'h6,
    MODE_XSTBY = 3'h7
  } slm_mode_t;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE, ST_HALT} slm_state_t;
  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic async;
    logic main_osc;
    logic timer_osc;
    logic comparator;
  } slm_gate_t;
  typedef struct packed {
    logic t2_cmp;
    logic t2_ovf;
    logic pin_chg;
    logic ext2;
    logic ext1;
    logic ext0;
  } slm_pins_t;
endpackage : slm_pkg
`default_nettype wire

// ===== logic/slm_sleep_ctrl.sv
/*
  Sleep-mode controller: arms on a register bit, enters one of five
  modes on the sleep instruction, gates clock domains and sequences wake-up.
  Assumes the CPU pulses sleep_instr_i for one cycle, that reset requests
  arrive synchronous, and that the clock-source strap is stable at reset.
*/
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module slm_sleep_ctrl
  import slm_pkg::*;
#(
  parameter int START_LONG = START_CK3
)(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // CPU and interrupt side
  input wire logic sleep_instr_i,
  input wire logic periph_irq_i,
  input wire logic spm_ee_irq_i,
  input wire logic reset_req_i,
  input wire logic global_ie_i,
  input wire logic [1:0] timer2_irq_en_i,
  input wire slm_pins_t wake_pins_i,
  input wire logic [3:0] clock_source_fuses_i,
  // Clock domain gates and sequencing
  output slm_gate_t clk_gate_o,
  output logic wake_irq_o,
  output logic restart_vec_o,
  output logic sleeping_o
);

  // Register state
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] cstat_q, cstat_d;
  logic [7:0] cext_q, cext_d;
  logic [7:0] aux_q, aux_d;
  logic [7:0] rdata_q, rdata_d;
  logic xtal_q, xtal_d;
  slm_mode_t mode_q, mode_d;
  slm_state_t st_q, st_d;
  always_comb
  begin
    ctrl_d = ctrl_q;
    cstat_d = cstat_q;
    cext_d = cext_q;
    aux_d = aux_q;
    rdata_d = RST_BYTE;
    if (reg_we_i)
    begin
      case (reg_addr_i)
        OFS_CTRL: ctrl_d = reg_wdata_i;
        OFS_CTRL_STAT: cstat_d = reg_wdata_i;
        OFS_CTRL_EXT: cext_d = reg_wdata_i;
        OFS_AUX: aux_d = reg_wdata_i;
        default: ;
      endcase
    end
    if (reg_re_i)
    begin
      case (reg_addr_i)
        OFS_CTRL: rdata_d = ctrl_q;
        OFS_CTRL_STAT: rdata_d = cstat_q;
        OFS_CTRL_EXT: rdata_d = cext_q;
        OFS_AUX: rdata_d = aux_q;
        OFS_STATE: rdata_d = {xtal_q, mode_q, 2'h0, st_q};
        default: rdata_d = RST_BYTE;
      endcase
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= RST_BYTE;
      cstat_q <= RST_BYTE;
      cext_q <= RST_BYTE;
      aux_q <= RST_BYTE;
      rdata_q <= RST_BYTE;
    end
    else if (clk_en_i)
    begin
      ctrl_q <= ctrl_d;
      cstat_q <= cstat_d;
      cext_q <= cext_d;
      aux_q <= aux_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata_o = rdata_q;

  // Strap capture: fuses are static, so one look after reset is enough
  logic [1:0] sut_q, sut_d;
  logic strap_q, strap_d;
  always_comb
  begin
    strap_d = 1'b1;
    xtal_d = xtal_q;
    sut_d = sut_q;
    if (!strap_q)
    begin
      xtal_d = clock_source_fuses_i >= XTAL_MIN_CODE;
      sut_d = clock_source_fuses_i[1:0];
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_q <= 1'b0;
      xtal_q <= 1'b0;
      sut_q <= 2'h0;
    end
    else if (clk_en_i)
    begin
      strap_q <= strap_d;
      xtal_q <= xtal_d;
      sut_q <= sut_d;
    end
  end

  // Pin synchronisers: a change counts once stages two and three agree
  localparam int NPIN = $bits(slm_pins_t);
  logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [NPIN-1:0] pin_d;
  slm_pins_t pins;
  always_comb
  begin
    pin_d = pin_q;
    for (int i = 0; i < NPIN; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        pin_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end
    else if (clk_en_i)
    begin
      s1_q <= wake_pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end
  assign pins = slm_pins_t'(pin_q);

  // Mode decode and wake sources
  logic [2:0] sel;
  logic sel_ok, arm, lvl0, lvl1, t2_async, t2_wake, wake_req;
  assign sel = {cstat_q[SEL_HI_BIT], ctrl_q[SEL_MID_BIT], cext_q[SEL_LO_BIT]};
  assign arm = ctrl_q[ARM_BIT];
  assign t2_async = aux_q[T2_ASYNC_BIT];
  assign lvl0 = ctrl_q[SENSE0_LSB +: 2] == SENSE_LEVEL;
  assign lvl1 = ctrl_q[SENSE1_LSB +: 2] == SENSE_LEVEL;
  assign t2_wake = global_ie_i && t2_async &&
    ((pins.t2_ovf && timer2_irq_en_i[0]) || (pins.t2_cmp && timer2_irq_en_i[1]));
  always_comb
  begin
    sel_ok = 1'b0;
    case (sel)
      MODE_IDLE, MODE_PDOWN, MODE_PSAVE: sel_ok = 1'b1;
      MODE_STBY, MODE_XSTBY: sel_ok = xtal_q;
      default: sel_ok = 1'b0;
    endcase
    wake_req = pins.ext2 || pins.pin_chg || (pins.ext0 && lvl0) || (pins.ext1 && lvl1);
    case (mode_q)
      MODE_IDLE: wake_req = pins.ext0 || pins.ext1 || pins.ext2 || pins.pin_chg ||
        pins.t2_ovf || pins.t2_cmp || periph_irq_i || spm_ee_irq_i;
      MODE_PSAVE, MODE_XSTBY: wake_req = wake_req || t2_wake;
      default: ;
    endcase
  end

  // Sleep sequencer; the longest start-up count shrinks in simulation through START_LONG
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic wirq_q, wirq_d, rvec_q, rvec_d;
  function automatic logic [CNT_W-1:0] start_len(input logic [1:0] sut);
    case (sut)
      2'h0: start_len = CNT_W'(START_CK0 - 1);
      2'h1: start_len = CNT_W'(START_CK1 - 1);
      2'h2: start_len = CNT_W'(START_CK2 - 1);
      default: start_len = CNT_W'(START_LONG - 1);
    endcase
  endfunction : start_len
  always_comb
  begin
    st_d = st_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    wirq_d = 1'b0;
    rvec_d = 1'b0;
    case (st_q)
      ST_RUN:
      begin
        if (sleep_instr_i && arm && sel_ok)
        begin
          st_d = ST_SLEEP;
          mode_d = slm_mode_t'(sel);
        end
      end
      ST_SLEEP:
      begin
        if (wake_req)
        begin
          st_d = ST_WAKE;
          case (mode_q)
            MODE_IDLE: st_d = ST_HALT;
            MODE_STBY, MODE_XSTBY: cnt_d = CNT_W'(STBY_CK - 1);
            default: cnt_d = start_len(sut_q);
          endcase
          if (mode_q == MODE_IDLE)
          begin
            cnt_d = CNT_W'(HALT_CK - 1);
          end
        end
      end
      ST_WAKE:
      begin
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == '0)
        begin
          st_d = ST_HALT;
          cnt_d = CNT_W'(HALT_CK - 1);
        end
      end
      ST_HALT:
      begin
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == '0)
        begin
          st_d = ST_RUN;
          wirq_d = 1'b1;
        end
      end
      default: st_d = ST_RUN;
    endcase
    if (reset_req_i && st_q != ST_RUN)
    begin
      st_d = ST_RUN;
      cnt_d = '0;
      rvec_d = 1'b1;
    end
  end

  // Gate bundle follows the next state so it lines up with st_q
  slm_gate_t gate_q, gate_d;
  logic slp_q, slp_d;
  always_comb
  begin
    gate_d = '{core: 1'b1, flash: 1'b1, io: 1'b1, async: 1'b1, main_osc: 1'b1,
      timer_osc: t2_async, comparator: !aux_q[CMP_OFF_BIT]};
    if (st_d == ST_SLEEP)
    begin
      // Core is gated, never reset, so its registers and SRAM hold
      gate_d.core = 1'b0;
      gate_d.flash = 1'b0;
      gate_d.comparator = 1'b0;
      gate_d.io = 1'b0;
      gate_d.async = t2_async && (mode_d == MODE_PSAVE || mode_d == MODE_XSTBY);
      gate_d.timer_osc = gate_d.async;
      gate_d.main_osc = mode_d == MODE_STBY || mode_d == MODE_XSTBY;
      if (mode_d == MODE_IDLE)
      begin
        gate_d.io = 1'b1;
        gate_d.async = 1'b1;
        gate_d.main_osc = 1'b1;
        gate_d.timer_osc = t2_async;
        gate_d.comparator = !aux_q[CMP_OFF_BIT];
      end
    end
    else if (st_d != ST_RUN)
    begin
      gate_d.core = 1'b0;
      gate_d.flash = 1'b0;
    end
    slp_d = !gate_d.core;
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q <= ST_RUN;
      mode_q <= MODE_IDLE;
      cnt_q <= '0;
      wirq_q <= 1'b0;
      rvec_q <= 1'b0;
      gate_q <= '1;
      slp_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_q <= st_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      wirq_q <= wirq_d;
      rvec_q <= rvec_d;
      gate_q <= gate_d;
      slp_q <= slp_d;
    end
  end
  assign clk_gate_o = gate_q;
  assign wake_irq_o = wirq_q;
  assign restart_vec_o = rvec_q;
  assign sleeping_o = slp_q;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i || !clk_en_i);
  noop_sleep_a: assert property (st_q == ST_RUN && sleep_instr_i && !arm |=>
    st_q == ST_RUN && clk_gate_o.core) else $error("unarmed sleep gated");
  enter_sleep_a: assert property (st_q == ST_RUN && sleep_instr_i && arm &&
    (sel == 3'h0 || sel == 3'h2) |=> st_q == ST_SLEEP && !clk_gate_o.core)
    else $error("armed sleep not entered");
  sel_rsvd_a: assert property (st_q == ST_RUN && sleep_instr_i && sel == 3'h1
    |=> st_q == ST_RUN) else $error("reserved select slept");
  idle_gate_a: assert property (st_q == ST_SLEEP && mode_q == MODE_IDLE |->
    clk_gate_o.io && clk_gate_o.async && !clk_gate_o.core && !clk_gate_o.flash)
    else $error("idle gating wrong");
  pdown_gate_a: assert property (st_q == ST_SLEEP && mode_q == MODE_PDOWN |->
    !clk_gate_o.io && !clk_gate_o.main_osc && !clk_gate_o.async)
    else $error("power-down gating wrong");
  halt_four_a: assert property (disable iff (!resetn_i || !clk_en_i || reset_req_i)
    $rose(st_q == ST_HALT) |->
    (st_q == ST_HALT && !clk_gate_o.core)[*4] ##1 wake_irq_o)
    else $error("halt not four cycles");
  reset_wake_a: assert property (st_q != ST_RUN && reset_req_i |=>
    st_q == ST_RUN && restart_vec_o) else $error("reset did not restart");
  stby_six_a: assert property (disable iff (!resetn_i || !clk_en_i || reset_req_i)
    st_q == ST_SLEEP && mode_q == MODE_STBY && wake_req && !reset_req_i |=>
    (st_q == ST_WAKE)[*6] ##1 st_q == ST_HALT)
    else $error("standby wake not six cycles");
  pd_src_a: assert property (st_q == ST_SLEEP && mode_q != MODE_IDLE &&
    pin_q == '0 && !reset_req_i |=> st_q == ST_SLEEP)
    else $error("peripheral woke deep sleep");
  t2_wake_a: assert property (st_q == ST_SLEEP && mode_q == MODE_PSAVE &&
    t2_wake && !reset_req_i |=> st_q == ST_WAKE) else $error("timer-2 wake lost");
  stby_xtal_a: assert property (st_q == ST_RUN && sleep_instr_i && sel == 3'h6 &&
    !xtal_q |=> st_q == ST_RUN) else $error("standby without crystal");
  idle_cov_c: cover property (st_q == ST_SLEEP && mode_q == MODE_IDLE ##1 st_q == ST_HALT);
  pd_cov_c: cover property (st_q == ST_SLEEP && mode_q == MODE_PDOWN ##1 st_q == ST_WAKE);
  rst_cov_c: cover property (st_q == ST_WAKE && reset_req_i);
  xs_cov_c: cover property (st_q == ST_SLEEP && mode_q == MODE_XSTBY);

endmodule : slm_sleep_ctrl
`default_nettype wire

// ===== sim/slm_irq_model.sv
/*
  Far-side model: interrupt and reset sources seen by the sleep controller.
  Assumes one system clock; the bench asks for a source with fire_i.
*/
`timescale 1ns/1ps
`default_nettype none
module slm_irq_model
  import slm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Bench requests
  input wire logic fire_i,
  input wire logic clear_i,
  input wire logic [2:0] src_i,
  // Controller answers
  input wire logic wake_irq_i,
  input wire logic restart_vec_i,
  // Levels toward the controller
  output var slm_pins_t wake_pins_o,
  output var logic periph_irq_o,
  output var logic reset_req_o
);
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  always_comb
  begin
    hold_d = hold_q;
    // Held until answered or cleared by clear_i: a short level would be lost in the synchroniser
    if (wake_irq_i || restart_vec_i || clear_i)
    begin
      hold_d = 8'h00;
    end
    if (fire_i)
    begin
      hold_d[src_i] = 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      hold_q <= 8'h00;
    end
    else
    begin
      hold_q <= hold_d;
    end
  end
  assign wake_pins_o = hold_q[5:0];
  assign periph_irq_o = hold_q[6];
  assign reset_req_o = hold_q[7];
endmodule : slm_irq_model
`default_nettype wire

// ===== sim/slm_sleep_ctrl_tb.sv
/*
  Self-checking bench of the sleep-mode controller.
  Assumes a crystal strap with the longest start-up code, shortened to 20 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module slm_sleep_ctrl_tb;
  import slm_pkg::*;
  localparam int SL = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic sleep_in = 1'b0;
  logic gie = 1'b0;
  logic [1:0] t2en = 2'h0;
  logic [3:0] fuses = 4'hb;
  logic fire = 1'b0;
  logic clr = 1'b0;
  logic spm = 1'b0;
  logic [2:0] src = 3'h0;
  logic [7:0] rdata;
  slm_pins_t pins;
  slm_gate_t gate;
  logic periph, rreq, wirq, rvec, slp;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  slm_irq_model far (.ref_clk_i(clk), .resetn_i(rstn), .fire_i(fire), .clear_i(clr),
    .src_i(src), .wake_irq_i(wirq), .restart_vec_i(rvec), .wake_pins_o(pins),
    .periph_irq_o(periph), .reset_req_o(rreq));
  slm_sleep_ctrl #(.START_LONG(SL)) dut (.ref_clk_i(clk), .resetn_i(rstn), .clk_en_i(1'b1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .sleep_instr_i(sleep_in), .periph_irq_i(periph),
    .spm_ee_irq_i(spm), .reset_req_i(rreq), .global_ie_i(gie), .timer2_irq_en_i(t2en),
    .wake_pins_i(pins), .clock_source_fuses_i(fuses), .clk_gate_o(gate),
    .wake_irq_o(wirq), .restart_vec_o(rvec), .sleeping_o(slp));
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // A hang must still reach the verdict
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd
  task automatic setm(input logic [2:0] m, input logic arm, input logic [1:0] aux);
    wr(OFS_CTRL_STAT, {2'h0, m[2], 5'h00});
    wr(OFS_CTRL, {2'h0, arm, m[1], 4'h0});
    wr(OFS_CTRL_EXT, {m[0], 7'h00});
    wr(OFS_AUX, {6'h00, aux});
  endtask : setm
  task automatic go(input logic [6:0] g);
    @(posedge clk);
    sleep_in <= 1'b1;
    @(posedge clk);
    sleep_in <= 1'b0;
    tick(1);
    chk({1'b0, gate}, {1'b0, g});
  endtask : go
  task automatic req(input logic [2:0] s);
    @(posedge clk);
    fire <= 1'b1;
    src <= s;
    @(posedge clk);
    fire <= 1'b0;
  endtask : req
  task automatic wake(input logic [2:0] s, output int n, output logic [1:0] got);
    req(s);
    n = 1;
    while ({wirq, rvec} === 2'b00 && n < 200)
    begin
      tick(1);
      n++;
    end
    got = {wirq, rvec};
  endtask : wake
  // Wake, time the exit, then check run gates and that a disarming CTRL write reads back
  task automatic fin(input logic [2:0] s, input int lo, input int hi, input logic [2:0] m,
    input logic [1:0] aux);
    int n;
    logic [1:0] got;
    wake(s, n, got);
    chk({6'h00, got}, 8'h02);
    chk({7'h00, n >= lo && n <= hi}, 8'h01);
    chk({slp, gate}, {1'b0, 5'h1f, aux[0], ~aux[1]});
    wr(OFS_CTRL, {3'h0, m[1], 4'h0});
    rd(OFS_CTRL, {3'h0, m[1], 4'h0});
  endtask : fin
  task automatic t_regs;
    rd(OFS_CTRL, RST_BYTE);
    rd(OFS_CTRL_STAT, RST_BYTE);
    wr(OFS_CTRL, 8'h5a);
    wr(OFS_CTRL_STAT, 8'ha5);
    rd(OFS_CTRL, 8'h5a);
    tick(1);
    chk(rdata, 8'h00);
    rd(OFS_CTRL_STAT, 8'ha5);
    rd(3'h7, 8'h00);
    rd(OFS_STATE, 8'h80);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL_STAT, 8'h00);
    $display("Done: registers");
  endtask : t_regs
  task automatic t_noop;
    // Running gates: timer oscillator follows the async select bit, here clear
    setm(3'h0, 1'b0, 2'h0);
    go(7'h7d);
    setm(3'h1, 1'b1, 2'h0);
    go(7'h7d);
    setm(3'h4, 1'b1, 2'h0);
    go(7'h7d);
    setm(3'h5, 1'b1, 2'h0);
    go(7'h7d);
    $display("Done: no-op sleeps");
  endtask : t_noop
  task automatic t_idle;
    setm(3'h0, 1'b1, 2'h2);
    go(7'b0011100);
    fin(3'h6, HALT_CK + 1, HALT_CK + 6, 3'h0, 2'h2);
    $display("Done: idle");
  endtask : t_idle
  task automatic t_pdown;
    setm(3'h2, 1'b1, 2'h0);
    go(7'h00);
    @(posedge clk);
    spm <= 1'b1;
    req(3'h6);
    tick(12);
    chk({7'h00, slp}, 8'h01);
    @(posedge clk);
    clr <= 1'b1;
    spm <= 1'b0;
    @(posedge clk);
    clr <= 1'b0;
    fin(3'h0, SL + HALT_CK + 1, SL + HALT_CK + 12, 3'h2, 2'h0);
    $display("Done: power-down");
  endtask : t_pdown
  task automatic t_psave;
    @(posedge clk);
    gie <= 1'b1;
    t2en <= 2'h3;
    // Asynchronous timer selected, so power-save is the right choice here
    setm(3'h3, 1'b1, 2'h1);
    go(7'b0001010);
    fin(3'h4, SL + HALT_CK + 1, SL + HALT_CK + 12, 3'h3, 2'h1);
    setm(3'h7, 1'b1, 2'h1);
    go(7'b0001110);
    fin(3'h5, STBY_CK + HALT_CK + 1, STBY_CK + HALT_CK + 12, 3'h7, 2'h1);
    $display("Done: power-save");
  endtask : t_psave
  task automatic t_stby;
    setm(3'h6, 1'b1, 2'h0);
    go(7'b0000100);
    fin(3'h2, STBY_CK + HALT_CK + 1, STBY_CK + HALT_CK + 12, 3'h6, 2'h0);
    $display("Done: standby");
  endtask : t_stby
  task automatic t_rst;
    int n;
    logic [1:0] got;
    setm(3'h2, 1'b1, 2'h0);
    go(7'h00);
    wake(3'h7, n, got);
    chk({6'h00, got}, 8'h01);
    tick(1);
    chk({7'h00, slp}, 8'h00);
    wr(OFS_CTRL, 8'h00);
    $display("Done: reset in sleep");
  endtask : t_rst
  task automatic t_noxtal;
    rstn <= 1'b0;
    fuses <= 4'h3;
    tick(6);
    rstn <= 1'b1;
    tick(3);
    rd(OFS_STATE, 8'h00);
    setm(3'h6, 1'b1, 2'h0);
    go(7'h7d);
    setm(3'h7, 1'b1, 2'h1);
    go(7'h7f);
    $display("Done: no crystal");
  endtask : t_noxtal
  initial
  begin
    tick(6);
    rstn <= 1'b1;
    tick(3);
    t_regs();
    t_noop();
    t_idle();
    t_pdown();
    t_psave();
    t_stby();
    t_rst();
    t_noxtal();
    complete_run();
  end
endmodule : slm_sleep_ctrl_tb
`default_nettype wire
